// [inc/cg_params.svh]
// constants for the core glue block: bit positions, address windows, timing counts
// assumes inclusion by every design file that decodes control bytes
`ifndef CG_PARAMS_SVH
`define CG_PARAMS_SVH
`define CG_TX_START_POS 1
`define CG_TX_CLEAR_POS 0
`define CG_RX_START_POS 1
`define CG_RX_CLEAR_POS 0
`define CG_LOOPBACK_POS 7
`define CG_HOST_IRQ_POS 0
`define CG_LED_VALUE_LSB 0
`define CG_LED_DIR_LSB 2
`define CG_HOST_ACCEPT_DELAY 3'h4
`define CG_BITS_PER_BYTE 4'h8
`define CG_BOOT_VECTOR 20'hffff0
`define CG_BOOT_FLASH_ADDR 17'h1fff0
`define CG_RESERVED_LO 20'h00440
`define CG_RESERVED_HI 20'h0047f
`define CG_CARD_INFO_LO 20'hffc00
`define CG_CARD_INFO_HI 20'hfffef
`endif

// [inc/cg_pkg.sv]
// state types for the core glue block
// assumes nothing beyond a SystemVerilog compiler
package cg_pkg;
  typedef enum logic [2:0] {CG_TX_IDLE = 3'h1, CG_TX_FETCH = 3'h2, CG_TX_SHIFT = 3'h4} cg_tx_state_t;
  typedef enum logic [2:0] {CG_SL_IDLE = 3'h1, CG_SL_ACCESS = 3'h2, CG_SL_FINISH = 3'h4} cg_slave_state_t;
  typedef enum logic [2:0] {CG_ARB_IDLE = 3'h1, CG_ARB_CORE = 3'h2, CG_ARB_HOST = 3'h4} cg_arb_state_t;
  typedef enum logic [1:0] {CG_SLP_AWAKE = 2'h1, CG_SLP_ASLEEP = 2'h2} cg_sleep_state_t;
  typedef enum logic [1:0] {CG_PNP_IDLE = 2'h1, CG_PNP_CONFIG = 2'h2} cg_pnp_state_t;
endpackage

// [logic/cg_fifo.sv]
// byte fifo with registered read data, emptied only by its clear input
// assumes one clock; deliberately has no reset so stored data survives any reset
`timescale 1ns/10ps
module cg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic i_push_valid,
  output logic o_push_ready,
  input wire logic [WIDTH-1:0] i_push_data,
  input wire logic i_pop_ready,
  output logic o_pop_valid,
  output logic [WIDTH-1:0] o_pop_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign o_push_ready = (o_count != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign o_pop_valid = (o_count != '0);
  assign push = i_push_valid && o_push_ready;
  assign pop = i_pop_ready && o_pop_valid;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_push_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (pop) begin
      o_pop_data <= mem[rd_ptr];
    end
  end

  // pointers move only on traffic or clear, never on reset
  always_ff @(posedge i_clock) begin
    if (i_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        o_count <= o_count + 1'b1;
      end else if (pop && !push) begin
        o_count <= o_count - 1'b1;
      end
    end
  end
endmodule

// [logic/cg_core_glue.sv]
// glue between the embedded core and the transceiver and host bus units
// assumes one 40 MHz clock, synchronous pin inputs and fifo clears issued once after power-up
`timescale 1ns/10ps
`include "cg_params.svh"
module cg_core_glue #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8,
  parameter int BIT_DIV = 4,
  parameter int EXTRA_IRQS = 4
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_tx_irq_status,
  input wire logic [7:0] i_rx_irq_status,
  input wire logic [EXTRA_IRQS-1:0] i_extra_irq_source,
  input wire logic [EXTRA_IRQS-1:0] i_extra_irq_enable,
  input wire logic i_user_interrupt_pin,
  input wire logic i_user_irq_enable,
  output logic o_core_irq_line_zero,
  output logic o_core_irq_line_one,
  input wire logic i_host_cmd_write,
  input wire logic [7:0] i_host_cmd_wdata,
  input wire logic i_core_host_irq_clear,
  input wire logic i_host_reg_two_write,
  input wire logic [7:0] i_host_reg_two_wdata,
  output logic [7:0] o_host_register_two,
  input wire logic i_host_reg_three_write,
  input wire logic [6:0] i_host_reg_three_wdata,
  output logic [6:0] o_host_register_three,
  input wire logic i_tx_fifo_write,
  input wire logic [7:0] i_tx_fifo_wdata,
  input wire logic i_rx_fifo_read,
  output logic [7:0] o_rx_fifo_rdata,
  output logic o_rx_dma_request,
  output logic o_tx_dma_request,
  input wire logic i_tx_control_write,
  input wire logic [7:0] i_tx_control_wdata,
  input wire logic i_rx_control_write,
  input wire logic [7:0] i_rx_control_wdata,
  input wire logic i_config_three_write,
  input wire logic [7:0] i_config_three_wdata,
  output logic o_loopback_enable,
  output logic o_tx_serial,
  input wire logic i_rx_serial,
  output logic o_rx_overrun,
  output logic o_delimiter_owner_rx,
  input wire logic i_led_core_write,
  input wire logic [3:0] i_led_core_wdata,
  input wire logic i_led_host_write,
  input wire logic [3:0] i_led_host_wdata,
  input wire logic [1:0] i_led_in,
  output logic [1:0] o_led_out,
  output logic [1:0] o_led_oe,
  output logic [1:0] o_led_level,
  output logic o_core_reset,
  input wire logic i_host_select,
  output logic o_host_slave_ready,
  output logic o_host_data_oe,
  output logic [7:0] o_host_rdata,
  output logic o_host_ack,
  input wire logic i_core_mem_req,
  input wire logic i_host_mem_req,
  output logic o_core_mem_grant,
  output logic o_host_mem_grant,
  input wire logic i_sleep_request,
  input wire logic i_wake_request,
  output logic o_awake,
  input wire logic i_pnp_start,
  input wire logic i_pnp_done,
  output logic o_pnp_busy,
  input wire logic [19:0] i_core_addr,
  output logic [16:0] o_flash_addr,
  output logic o_reserved_access
);
  localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
  cg_pkg::cg_tx_state_t tx_state;
  cg_pkg::cg_slave_state_t slave_state;
  cg_pkg::cg_arb_state_t arb_state;
  cg_pkg::cg_sleep_state_t sleep_state;
  cg_pkg::cg_pnp_state_t pnp_state;
  logic host_irq_flag;
  logic tx_start_bit;
  logic rx_start_bit;
  logic [DW-1:0] div_count;
  logic bit_tick;
  logic [7:0] tx_shift;
  logic [3:0] tx_bits;
  logic [7:0] rx_shift;
  logic [3:0] rx_bits;
  logic rx_sample;
  logic rx_bit;
  logic rx_byte_valid;
  logic [7:0] buf0;
  logic [7:0] buf1;
  logic [1:0] buf_count;
  logic buf_push;
  logic buf_pop;
  logic [3:0] led_reg;
  logic [2:0] accept_count;
  logic tx_push_ready;
  logic tx_pop_valid;
  logic tx_pop;
  logic [7:0] tx_pop_data;
  logic [$clog2(TX_DEPTH+1)-1:0] tx_count;
  logic rx_push_ready;
  logic rx_pop_valid;
  logic [$clog2(RX_DEPTH+1)-1:0] rx_count;
  logic tx_clear;
  logic rx_clear;
  logic tx_start_set;
  logic rx_start_set;

  assign tx_clear = i_tx_control_write && i_tx_control_wdata[`CG_TX_CLEAR_POS];
  assign rx_clear = i_rx_control_write && i_rx_control_wdata[`CG_RX_CLEAR_POS];
  assign tx_start_set = i_tx_control_write && i_tx_control_wdata[`CG_TX_START_POS];
  assign rx_start_set = i_rx_control_write && i_rx_control_wdata[`CG_RX_START_POS];

  // interrupt routing, one fixed line per source unit
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_core_irq_line_zero <= 1'b0;
    end else begin
      o_core_irq_line_zero <= (|i_tx_irq_status) || (|i_rx_irq_status) ||
        (|(i_extra_irq_source & i_extra_irq_enable)) || (i_user_interrupt_pin && i_user_irq_enable);
    end
  end

  // a new host write in the clearing cycle keeps the flag set
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      host_irq_flag <= 1'b0;
    end else if (i_host_cmd_write && i_host_cmd_wdata[`CG_HOST_IRQ_POS]) begin
      host_irq_flag <= 1'b1;
    end else if (i_core_host_irq_clear) begin
      host_irq_flag <= 1'b0;
    end
  end
  assign o_core_irq_line_one = host_irq_flag;

  // these two host registers deliberately ride through every reset
  always_ff @(posedge i_clock) begin
    if (i_host_reg_two_write) begin
      o_host_register_two <= i_host_reg_two_wdata;
    end
    if (i_host_reg_three_write) begin
      o_host_register_three <= i_host_reg_three_wdata;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_start_bit <= 1'b0;
      rx_start_bit <= 1'b0;
      o_loopback_enable <= 1'b0;
      o_delimiter_owner_rx <= 1'b0;
    end else begin
      if (i_tx_control_write) begin
        tx_start_bit <= i_tx_control_wdata[`CG_TX_START_POS];
      end
      if (i_rx_control_write) begin
        rx_start_bit <= i_rx_control_wdata[`CG_RX_START_POS];
      end
      if (i_config_three_write) begin
        o_loopback_enable <= i_config_three_wdata[`CG_LOOPBACK_POS];
      end
      if (rx_start_set) begin
        o_delimiter_owner_rx <= 1'b1;
      end else if (tx_start_set) begin
        o_delimiter_owner_rx <= 1'b0;
      end
    end
  end

  cg_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .i_clock(i_clock),
    .i_clear(tx_clear),
    .i_push_valid(i_tx_fifo_write),
    .o_push_ready(tx_push_ready),
    .i_push_data(i_tx_fifo_wdata),
    .i_pop_ready(tx_pop),
    .o_pop_valid(tx_pop_valid),
    .o_pop_data(tx_pop_data),
    .o_count(tx_count)
  );

  cg_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .i_clock(i_clock),
    .i_clear(rx_clear),
    .i_push_valid(buf_count != 2'h0),
    .o_push_ready(rx_push_ready),
    .i_push_data(buf0),
    .i_pop_ready(i_rx_fifo_read),
    .o_pop_valid(rx_pop_valid),
    .o_pop_data(o_rx_fifo_rdata),
    .o_count(rx_count)
  );

  assign o_rx_dma_request = rx_pop_valid;
  assign o_tx_dma_request = tx_push_ready;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      div_count <= '0;
    end else begin
      div_count <= (div_count == DW'(BIT_DIV - 1)) ? '0 : div_count + 1'b1;
    end
  end
  assign bit_tick = (div_count == DW'(BIT_DIV - 1));

  // in loopback a byte is only fetched when the receive buffer can take it
  assign tx_pop = (tx_state == cg_pkg::CG_TX_IDLE) && tx_start_bit && tx_pop_valid &&
                  (!o_loopback_enable || buf_count == 2'h0);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_state <= cg_pkg::CG_TX_IDLE;
      tx_shift <= 8'h00;
      tx_bits <= 4'h0;
      o_tx_serial <= 1'b1;
    end else begin
      case (tx_state)
        cg_pkg::CG_TX_IDLE: begin
          o_tx_serial <= 1'b1;
          if (tx_pop) begin
            tx_state <= cg_pkg::CG_TX_FETCH;
          end
        end
        cg_pkg::CG_TX_FETCH: begin
          tx_shift <= tx_pop_data;
          tx_bits <= 4'h0;
          tx_state <= cg_pkg::CG_TX_SHIFT;
        end
        cg_pkg::CG_TX_SHIFT: begin
          if (!tx_start_bit) begin
            tx_state <= cg_pkg::CG_TX_IDLE;
          end else if (bit_tick) begin
            o_tx_serial <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bits <= tx_bits + 1'b1;
            if (tx_bits == `CG_BITS_PER_BYTE - 1'b1) begin
              tx_state <= cg_pkg::CG_TX_IDLE;
            end
          end
        end
        default: tx_state <= cg_pkg::CG_TX_IDLE;
      endcase
    end
  end

  // loopback samples the bit that the serializer launches on the same tick
  assign rx_sample = rx_start_bit && bit_tick &&
                     (!o_loopback_enable || (tx_state == cg_pkg::CG_TX_SHIFT && tx_start_bit));
  assign rx_bit = o_loopback_enable ? tx_shift[0] : i_rx_serial;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_shift <= 8'h00;
      rx_bits <= 4'h0;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (!rx_start_bit) begin
        rx_bits <= 4'h0;
      end else if (rx_sample) begin
        rx_shift <= {rx_bit, rx_shift[7:1]};
        if (rx_bits == `CG_BITS_PER_BYTE - 1'b1) begin
          rx_bits <= 4'h0;
          rx_byte_valid <= 1'b1;
        end else begin
          rx_bits <= rx_bits + 1'b1;
        end
      end
    end
  end

  // two-entry buffer absorbs a word while the rx fifo is full
  assign buf_push = rx_byte_valid && (buf_count != 2'h2);
  assign buf_pop = (buf_count != 2'h0) && rx_push_ready;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      buf_count <= 2'h0;
      buf0 <= 8'h00;
      buf1 <= 8'h00;
    end else begin
      case ({buf_push, buf_pop})
        2'b10: begin
          if (buf_count == 2'h0) begin
            buf0 <= rx_shift;
          end else begin
            buf1 <= rx_shift;
          end
          buf_count <= buf_count + 1'b1;
        end
        2'b01: begin
          buf0 <= buf1;
          buf_count <= buf_count - 1'b1;
        end
        2'b11: begin
          if (buf_count == 2'h1) begin
            buf0 <= rx_shift;
          end else begin
            buf0 <= buf1;
            buf1 <= rx_shift;
          end
        end
        default: buf_count <= buf_count;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_rx_overrun <= 1'b0;
    end else if (rx_byte_valid && buf_count == 2'h2) begin
      o_rx_overrun <= 1'b1;
    end else if (i_rx_control_write) begin
      o_rx_overrun <= 1'b0;
    end
  end

  // core write wins when both sides write the led register together
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      led_reg <= 4'h0;
    end else if (i_led_core_write) begin
      led_reg <= i_led_core_wdata;
    end else if (i_led_host_write) begin
      led_reg <= i_led_host_wdata;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_led
    assign o_led_out[g] = led_reg[`CG_LED_VALUE_LSB + g];
    assign o_led_oe[g] = led_reg[`CG_LED_DIR_LSB + g];
    always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
        o_led_level[g] <= 1'b0;
      end else begin
        o_led_level[g] <= o_led_oe[g] ? o_led_out[g] : i_led_in[g];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      accept_count <= 3'h0;
    end else if (accept_count != `CG_HOST_ACCEPT_DELAY) begin
      accept_count <= accept_count + 1'b1;
    end
  end
  assign o_host_slave_ready = (accept_count == `CG_HOST_ACCEPT_DELAY);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      slave_state <= cg_pkg::CG_SL_IDLE;
      o_host_rdata <= 8'h00;
    end else begin
      case (slave_state)
        cg_pkg::CG_SL_IDLE: begin
          if (i_host_select && o_host_slave_ready) begin
            o_host_rdata <= o_host_register_two;
            slave_state <= cg_pkg::CG_SL_ACCESS;
          end
        end
        cg_pkg::CG_SL_ACCESS: slave_state <= cg_pkg::CG_SL_FINISH;
        cg_pkg::CG_SL_FINISH: slave_state <= cg_pkg::CG_SL_IDLE;
        default: slave_state <= cg_pkg::CG_SL_IDLE;
      endcase
    end
  end
  assign o_host_data_oe = (slave_state == cg_pkg::CG_SL_ACCESS);
  assign o_host_ack = (slave_state == cg_pkg::CG_SL_FINISH);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      arb_state <= cg_pkg::CG_ARB_IDLE;
    end else begin
      case (arb_state)
        cg_pkg::CG_ARB_IDLE: begin
          if (i_core_mem_req) begin
            arb_state <= cg_pkg::CG_ARB_CORE;
          end else if (i_host_mem_req) begin
            arb_state <= cg_pkg::CG_ARB_HOST;
          end
        end
        cg_pkg::CG_ARB_CORE: if (!i_core_mem_req) arb_state <= cg_pkg::CG_ARB_IDLE;
        cg_pkg::CG_ARB_HOST: if (!i_host_mem_req) arb_state <= cg_pkg::CG_ARB_IDLE;
        default: arb_state <= cg_pkg::CG_ARB_IDLE;
      endcase
    end
  end
  assign o_core_mem_grant = (arb_state == cg_pkg::CG_ARB_CORE);
  assign o_host_mem_grant = (arb_state == cg_pkg::CG_ARB_HOST);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sleep_state <= cg_pkg::CG_SLP_AWAKE;
      pnp_state <= cg_pkg::CG_PNP_IDLE;
    end else begin
      case (sleep_state)
        cg_pkg::CG_SLP_AWAKE: if (i_sleep_request) sleep_state <= cg_pkg::CG_SLP_ASLEEP;
        cg_pkg::CG_SLP_ASLEEP: if (i_wake_request) sleep_state <= cg_pkg::CG_SLP_AWAKE;
        default: sleep_state <= cg_pkg::CG_SLP_AWAKE;
      endcase
      case (pnp_state)
        cg_pkg::CG_PNP_IDLE: if (i_pnp_start) pnp_state <= cg_pkg::CG_PNP_CONFIG;
        cg_pkg::CG_PNP_CONFIG: if (i_pnp_done) pnp_state <= cg_pkg::CG_PNP_IDLE;
        default: pnp_state <= cg_pkg::CG_PNP_IDLE;
      endcase
    end
  end
  assign o_awake = (sleep_state == cg_pkg::CG_SLP_AWAKE);
  assign o_pnp_busy = (pnp_state == cg_pkg::CG_PNP_CONFIG);

  // only the low address bits reach the flash, so the top vector folds down
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_flash_addr <= 17'h00000;
      o_reserved_access <= 1'b0;
    end else begin
      o_flash_addr <= i_core_addr[16:0];
      o_reserved_access <= (i_core_addr >= `CG_RESERVED_LO && i_core_addr <= `CG_RESERVED_HI) ||
        (i_core_addr >= `CG_CARD_INFO_LO && i_core_addr <= `CG_CARD_INFO_HI);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_release;
    $past(i_reset) && !i_reset;
  endsequence
  sequence s_tx_fetch;
    tx_pop ##1 tx_state == cg_pkg::CG_TX_FETCH ##1 tx_state == cg_pkg::CG_TX_SHIFT;
  endsequence

  a_irq_zero_route: assert property ((|i_tx_irq_status) |=> o_core_irq_line_zero && !o_core_irq_line_one ||
    $past(host_irq_flag) || $past(i_host_cmd_write)) else $error("tx status not routed to line zero");
  a_irq_one_source: assert property ($rose(o_core_irq_line_one) |->
    $past(i_host_cmd_write && i_host_cmd_wdata[`CG_HOST_IRQ_POS])) else $error("line one rose without host write");
  a_host_irq_set: assert property (i_host_cmd_write && i_host_cmd_wdata[`CG_HOST_IRQ_POS] |=>
    o_core_irq_line_one) else $error("host write did not raise line one");
  a_user_pin_irq: assert property (i_user_interrupt_pin && i_user_irq_enable |=> o_core_irq_line_zero)
    else $error("user pin did not raise line zero");
  a_rx_dma_req: assert property (rx_count != '0 |-> o_rx_dma_request) else $error("rx request low with data");
  a_tx_dma_req: assert property (tx_count != TX_DEPTH[$clog2(TX_DEPTH+1)-1:0] |-> o_tx_dma_request)
    else $error("tx request low with space");
  a_tx_fifo_push: assert property (i_tx_fifo_write && tx_push_ready && !tx_pop && !tx_clear |=>
    tx_count == $past(tx_count) + 1'b1) else $error("tx port write lost");
  a_loopback_load: assert property (s_tx_fetch |-> tx_shift == $past(tx_pop_data))
    else $error("serializer not loaded from tx fifo");
  a_delim_owner: assert property (tx_start_set && !rx_start_set |=> !o_delimiter_owner_rx)
    else $error("owner not given to tx");
  a_delim_rx_owner: assert property (rx_start_set |=> o_delimiter_owner_rx) else $error("owner not given to rx");
  a_slave_accept: assert property (s_release |-> !o_host_slave_ready [*4] ##1 o_host_slave_ready)
    else $error("host slave accept delay wrong");
  a_boot_fold: assert property (i_core_addr == `CG_BOOT_VECTOR |=> o_flash_addr == `CG_BOOT_FLASH_ADDR)
    else $error("boot fetch not at flash top");
endmodule

// [verification/cg_core_model.sv]
// core side model: counts requests raised on each core interrupt line
// assumes level requests from the glue block on one clock
`timescale 1ns/10ps
module cg_core_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_irq_zero,
  input wire logic i_irq_one,
  output logic [7:0] o_zero_events,
  output logic [7:0] o_one_events
);
  logic seen_zero;
  logic seen_one;
  // nested mode, vectors made inside the core: nothing is acknowledged back
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      {seen_zero, seen_one, o_zero_events, o_one_events} <= '0;
    end else begin
      seen_zero <= i_irq_zero;
      seen_one <= i_irq_one;
      if (i_irq_zero && !seen_zero) o_zero_events <= o_zero_events + 8'h01;
      if (i_irq_one && !seen_one) o_one_events <= o_one_events + 8'h01;
    end
  end
endmodule

// [verification/tb_top.sv]
// self-checking bench: interrupts, fifo ports, loopback, leds, host slave, reset
// assumes default block parameters and the core model beside the block
`timescale 1ns/10ps
module tb_top;
  logic i_clock = 1'h0, i_reset = 1'h1, i_user_irq_enable = 1'h1, i_rx_serial = 1'h1;
  logic i_core_mem_req = 1'h0, i_host_mem_req = 1'h0;
  logic [20:0] irq_src = 21'h000000;
  logic [7:0] wd = 8'h00, zero_events, one_events, o_host_register_two, o_rx_fifo_rdata, o_host_rdata;
  logic [3:0] i_extra_irq_enable = 4'hf;
  logic [1:0] i_led_in = 2'h2, o_led_out, o_led_oe, o_led_level;
  logic [19:0] i_core_addr = 20'h00000;
  logic [19:0] ra [7] = '{20'h0043f, 20'h00440, 20'h0047f, 20'h00480, 20'hffc00, 20'hfffef, 20'hffff0};
  logic [15:0] st = 16'h0000;
  logic [16:0] o_flash_addr;
  logic [6:0] o_host_register_three;
  logic o_core_irq_line_zero, o_core_irq_line_one, o_rx_dma_request, o_tx_dma_request, o_loopback_enable;
  logic o_tx_serial, o_rx_overrun, o_delimiter_owner_rx, o_core_reset, o_host_slave_ready, o_host_data_oe;
  logic o_host_ack, o_core_mem_grant, o_host_mem_grant, o_awake, o_pnp_busy, o_reserved_access;
  wire [7:0] i_tx_irq_status = irq_src[20:13], i_rx_irq_status = irq_src[12:5];
  wire [3:0] i_extra_irq_source = irq_src[4:1];
  wire i_user_interrupt_pin = irq_src[0];
  wire i_tx_fifo_write = st[0], i_tx_control_write = st[1], i_rx_control_write = st[2], i_config_three_write = st[3];
  wire i_host_cmd_write = st[4], i_host_reg_two_write = st[5], i_led_core_write = st[6], i_led_host_write = st[7];
  wire i_rx_fifo_read = st[8], i_host_select = st[9], i_core_host_irq_clear = st[10], i_host_reg_three_write = st[11];
  wire i_sleep_request = st[12], i_wake_request = st[13], i_pnp_start = st[14], i_pnp_done = st[15];
  wire [7:0] i_tx_fifo_wdata = wd, i_tx_control_wdata = wd, i_rx_control_wdata = wd, i_config_three_wdata = wd;
  wire [7:0] i_host_cmd_wdata = wd, i_host_reg_two_wdata = wd;
  wire [6:0] i_host_reg_three_wdata = wd[6:0];
  wire [3:0] i_led_core_wdata = wd[3:0], i_led_host_wdata = wd[3:0];
  int mismatches = 0, n_compared = 0, cycles = 0;
  cg_core_glue u_cg_core_glue (.*);
  cg_core_model u_cg_core_model (.i_clock(i_clock), .i_reset(i_reset), .i_irq_zero(o_core_irq_line_zero),
    .i_irq_one(o_core_irq_line_one), .o_zero_events(zero_events), .o_one_events(one_events));
  always #12.5 i_clock = ~i_clock;
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // one strobe per call; k picks the strobe, a gap cycle follows
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge i_clock);
    st <= 16'h0001 << k;
    wd <= d;
    @(posedge i_clock);
    st <= 16'h0000;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    tick(4);
    chk(o_core_reset, 1);
    chk({o_tx_serial, o_host_data_oe, o_host_ack, o_awake, o_pnp_busy, o_core_mem_grant, o_host_mem_grant,
      o_host_slave_ready}, 8'h90);
    tick(4);
    @(posedge i_clock) i_reset <= 1'h0;
    tick(3);
    chk({o_core_reset, o_host_slave_ready}, 2'h0);
    tick(1);
    chk(o_host_slave_ready, 1);
    wr(1, 8'h01);
    wr(2, 8'h01);
    chk({o_tx_dma_request, o_rx_dma_request}, 2'h2);
    for (int b = 0; b < 21; b++) begin
      @(posedge i_clock) irq_src <= 21'h000001 << b;
      tick(2);
      chk({o_core_irq_line_zero, o_core_irq_line_one}, 2'h2);
      @(posedge i_clock) irq_src <= 21'h000000;
      tick(2);
      chk(o_core_irq_line_zero, 0);
    end
    @(posedge i_clock) {i_user_irq_enable, i_extra_irq_enable, irq_src} <= {5'h00, 21'h00001f};
    tick(3);
    chk(o_core_irq_line_zero, 0);
    @(posedge i_clock) irq_src <= 21'h000000;
    wr(4, 8'hfe);
    chk(o_core_irq_line_one, 0);
    wr(4, 8'h01);
    chk({o_core_irq_line_zero, o_core_irq_line_one}, 2'h1);
    wr(10, 8'h00);
    chk(o_core_irq_line_one, 0);
    chk({zero_events, one_events}, 16'h1501);
    wr(6, 8'h0d);
    tick(2);
    chk({o_led_out, o_led_oe, o_led_level}, 6'h1d);
    wr(7, 8'h02);
    tick(2);
    chk({o_led_out, o_led_oe, o_led_level}, 6'h22);
    wr(5, 8'h5a);
    wr(11, 8'h33);
    wr(9, 8'h00);
    chk({o_host_data_oe, o_host_rdata}, 9'h15a);
    tick(1);
    chk(o_host_ack, 1);
    wr(12, 8'h00);
    wr(14, 8'h00);
    chk({o_awake, o_pnp_busy}, 2'h1);
    foreach (ra[i]) begin
      @(posedge i_clock) i_core_addr <= ra[i];
      tick(2);
      chk(o_reserved_access, ra[i] inside {[20'h00440:20'h0047f], [20'hffc00:20'hfffef]});
    end
    chk(o_flash_addr, 17'h1fff0);
    wr(3, 8'h80);
    chk(o_loopback_enable, 1);
    for (int i = 0; i < 8; i++) wr(0, 8'h3c ^ (8'h11 * i[7:0]));
    chk(o_tx_dma_request, 0);
    wr(2, 8'h02);
    wr(1, 8'h02);
    chk(o_delimiter_owner_rx, 0);
    tick(600);
    chk({o_rx_dma_request, o_rx_overrun}, 2'h2);
    wr(2, 8'h02);
    chk(o_delimiter_owner_rx, 1);
    for (int i = 0; i < 8; i++) begin
      wr(8, 8'h00);
      chk(o_rx_fifo_rdata, 8'h3c ^ (8'h11 * i[7:0]));
    end
    chk({o_rx_dma_request, o_tx_dma_request}, 2'h1);
    wr(1, 8'h00);
    for (int i = 0; i < 8; i++) wr(0, i[7:0]);
    @(posedge i_clock) i_core_mem_req <= 1'h1;
    tick(2);
    chk({o_core_mem_grant, o_host_mem_grant}, 2'h2);
    @(posedge i_clock) {i_core_mem_req, i_host_mem_req} <= 2'h1;
    tick(3);
    chk({o_core_mem_grant, o_host_mem_grant}, 2'h1);
    @(posedge i_clock) i_reset <= 1'h1;
    tick(3);
    chk({o_core_reset, o_awake, o_pnp_busy, o_loopback_enable, o_delimiter_owner_rx, o_core_mem_grant,
      o_host_mem_grant}, 7'h60);
    @(posedge i_clock) i_reset <= 1'h0;
    tick(40);
    chk({o_tx_dma_request, o_tx_serial, o_host_register_two, o_host_register_three}, 17'h0ad33);
    wr(1, 8'h01);
    chk(o_tx_dma_request, 1);
    wr(12, 8'h00);
    wr(13, 8'h00);
    wr(14, 8'h00);
    wr(15, 8'h00);
    chk({o_awake, o_pnp_busy}, 2'h2);
    finish_test;
  end
endmodule
